/* logic/pll_ctrl_pkg.sv */
/*
  Constants shared by the serial control logic and its auxiliary output port.
  Assumes the compiler sees this package before any module that names it.
*/
package pll_ctrl_pkg;
  // Open-mode frame layout: 24 data bits, 5 address bits, 3 chip address bits.
  localparam int FRAME_BITS = 32;
  localparam int DATA_BITS = 24;
  localparam int ADDR_BITS = 5;
  localparam int CHIP_BITS = 3;
  localparam logic [5:0] FRAME_BITS_CNT = 6'h20;
  localparam logic [2:0] CHIP_ADDR = 3'h0;
  // Register addresses.
  localparam logic [4:0] ADDR_ID = 5'h00;
  localparam logic [4:0] ADDR_POWER = 5'h01;
  localparam logic [4:0] ADDR_INT = 5'h03;
  localparam logic [4:0] ADDR_FRAC = 5'h04;
  localparam logic [4:0] ADDR_AUX = 5'h05;
  localparam logic [4:0] PTR_RST = 5'h00;
  // Address zero write fields.
  localparam int SWRST_BIT = 5;
  localparam int PTR_MSB = 4;
  // Power control register fields.
  localparam int POWER_W = 9;
  localparam logic [8:0] POWER_RST = 9'h002;
  localparam int PWR_PIN_SEL = 0;
  localparam int PWR_SPI_EN = 1;
  localparam int PWR_KEEP_LSB = 2;
  localparam int KEEP_N = 6;
  // Auxiliary port.
  localparam int AUX_W = 16;
  localparam logic [15:0] AUX_RST = 16'h0000;
  localparam logic [4:0] AUX_DATA_CYC = 5'h10;
  localparam logic [4:0] AUX_SEL_CYC = 5'h12;
  localparam logic [4:0] AUX_LAST_CYC = 5'h13;
  // Number of synchronised pins.
  localparam int PIN_N = 6;
endpackage

/* logic/pll_aux_serial_port.sv */
/*
  Auxiliary serial output port: shifts a 16-bit word out in open-mode framing
  at the comparison rate. Assumes the caller supplies a synchronised comparison
  clock level and a one-cycle pulse on each of its falling edges.
*/
`timescale 1ns/1ps
module pll_aux_serial_port (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic soft_rst_in,
  input wire logic start_in,
  input wire logic [15:0] word_in,
  input wire logic pfd_level_in,
  input wire logic pfd_fall_in,
  output logic aux_clk_out,
  output logic aux_data_out,
  output logic aux_sel_out
);
  logic pending_r;
  logic busy_r;
  logic [4:0] cyc_r;
  logic [15:0] hold_r;
  logic [15:0] shift_r;
  logic launch;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  assign launch = pending_r && !busy_r && pfd_fall_in;

  //////////////////////////////////////////////////////////////////////////////
  // A request that lands while a transfer runs is kept, so the newest word
  // still goes out; the set wins over the clear on launch.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pending_r <= 1'b0;
      hold_r <= pll_ctrl_pkg::AUX_RST;
    end else if (soft_rst_in) begin
      pending_r <= 1'b0;
      hold_r <= pll_ctrl_pkg::AUX_RST;
    end else begin
      if (start_in) begin
        pending_r <= 1'b1;
        hold_r <= word_in;
      end else if (launch) begin
        pending_r <= 1'b0;
      end
    end
  end

  // Cycle counter and shifter advance only on comparison clock falling edges.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0;
      cyc_r <= 5'h00;
      shift_r <= pll_ctrl_pkg::AUX_RST;
    end else if (soft_rst_in) begin
      busy_r <= 1'b0;
      cyc_r <= 5'h00;
      shift_r <= pll_ctrl_pkg::AUX_RST;
    end else if (launch) begin
      busy_r <= 1'b1;
      cyc_r <= 5'h00;
      shift_r <= hold_r;
    end else if (busy_r && pfd_fall_in) begin
      shift_r <= {shift_r[14:0], 1'b0};
      if (cyc_r == pll_ctrl_pkg::AUX_LAST_CYC) begin
        busy_r <= 1'b0;
      end else begin
        cyc_r <= cyc_r + 5'h01;
      end
    end
  end

  // Pins: clock only in the 16 data cycles, select in one overhead cycle.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aux_clk_out <= 1'b0;
      aux_data_out <= 1'b0;
      aux_sel_out <= 1'b0;
    end else begin
      aux_clk_out <= busy_r && (cyc_r < pll_ctrl_pkg::AUX_DATA_CYC) && pfd_level_in;
      aux_data_out <= busy_r && shift_r[15];
      aux_sel_out <= busy_r && (cyc_r == pll_ctrl_pkg::AUX_SEL_CYC);
    end
  end

  // A soft reset may cut a transfer short, so only a natural end is measured.
  aux_length_a: assert property ($fell(busy_r) && !$past(soft_rst_in)
                                 |-> $past(cyc_r) == 5'h13)
    else $error("Aux transfer did not last twenty cycles.");
  aux_clk_gate_a: assert property (busy_r && cyc_r >= 5'h10 |=> !aux_clk_out)
    else $error("Aux clock ran during overhead cycles.");
endmodule

/* logic/pll_serial_control_regs.sv */
/*
  Serial-port control logic of the synthesizer: open-mode host port, identifier,
  soft reset, read pointer, power control and the auxiliary output port.
  Assumes every pin input is asynchronous to clk_in and is much slower than it.
*/
// Notes on behaviour
// - Read-back works without select; select rising edge restores lock detect.
// - An auxiliary serial port sends one 16-bit word per transfer.
// - The auxiliary port uses the same open-mode framing as the host port.
// - A frequency change starts sending the stored auxiliary word.
// - Auxiliary bits run at the comparison rate, not the host clock.
// - One auxiliary transfer is 16 data cycles plus 4 overhead cycles.
// - Address zero reads a fixed 24-bit identifier that cannot be written.
// - Writing one to address zero bit 5 resets all registers and state.
// - Address zero bits 4 to 0 set the pointer for the next read.
// - Source bit set: the enable pin drives chip enable, low powers down.
// - Source bit clear: power bit 1 is chip enable, pin ignored.
// - Power bit 2 keeps bias generators on.
// - Power bit 3 keeps the phase detector on.
// - Power bit 4 keeps the charge pump on.
// - Power bit 5 keeps the reference buffer on.
// - Power bit 6 keeps the divider buffer on.
// - Power bit 7 keeps the output driver on.
// - Address five holds a 16-bit auxiliary word, reset to zero.
`timescale 1ns/1ps
module pll_serial_control_regs #(
  parameter logic [23:0] SUBSYS_ID = 24'h5a5a01 // Arbitrary value.
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  input wire logic port_select_strobe_in,
  input wire logic chip_enable_pin_in,
  input wire logic lock_detect_in,
  input wire logic pfd_clk_in,
  output logic lock_detect_serial_out,
  output logic lock_detect_serial_oe_out,
  output logic aux_clk_out,
  output logic aux_data_pin_out,
  output logic aux_sel_out,
  output logic chip_enable_out,
  output logic bias_en_out,
  output logic hold_phase_detector_active_out,
  output logic hold_charge_pump_active_out,
  output logic ref_buffer_en_out,
  output logic hold_divider_buffer_active_out,
  output logic hold_output_driver_active_out
);
  localparam int PS = pll_ctrl_pkg::PIN_N;

  logic [PS-1:0] pin_raw;
  logic [PS-1:0] sync1_r;
  logic [PS-1:0] sync2_r;
  logic [PS-1:0] sync3_r;
  logic [PS-1:0] filt_r;
  logic [PS-1:0] rise;
  logic [PS-1:0] fall;
  logic [31:0] frame_r;
  logic [5:0] bit_cnt_r;
  logic chip_ok_r;
  logic soft_rst_r;
  logic freq_chg_r;
  logic [4:0] ptr_r;
  logic [8:0] power_r;
  logic [15:0] aux_r;
  logic read_active_r;
  logic [23:0] rd_shift_r;
  logic [23:0] rd_word;
  logic wr_take;
  logic [23:0] wr_data;
  logic [4:0] wr_addr;
  logic ce;
  logic [pll_ctrl_pkg::KEEP_N-1:0] blk_en_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  assign pin_raw = {pfd_clk_in, lock_detect_in, chip_enable_pin_in,
                    port_select_strobe_in, sdi_in, sclk_in};

  //////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; a level is accepted only once stages two and
  // three agree, which rejects a single metastable sample.
  genvar gi;
  generate
    for (gi = 0; gi < PS; gi++) begin : g_sync
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          filt_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            filt_r[gi] <= sync3_r[gi];
          end
        end
      end
      assign rise[gi] = (sync2_r[gi] == sync3_r[gi]) && sync3_r[gi] && !filt_r[gi];
      assign fall[gi] = (sync2_r[gi] == sync3_r[gi]) && !sync3_r[gi] && filt_r[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Frame fields: data, register address, chip address, MSB first.
  assign wr_data = frame_r[31:8];
  assign wr_addr = frame_r[7:3];
  assign wr_take = rise[2] && (frame_r[2:0] == pll_ctrl_pkg::CHIP_ADDR);

  // Host frame shifter; the select rising edge commits the frame.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_r <= 32'h00000000;
      bit_cnt_r <= 6'h00;
      chip_ok_r <= 1'b1;
    end else if (soft_rst_r) begin
      frame_r <= 32'h00000000;
      bit_cnt_r <= 6'h00;
      chip_ok_r <= 1'b1;
    end else if (rise[2]) begin
      bit_cnt_r <= 6'h00;
      chip_ok_r <= (frame_r[2:0] == pll_ctrl_pkg::CHIP_ADDR);
    end else if (rise[0]) begin
      frame_r <= {frame_r[30:0], filt_r[1]};
      if (bit_cnt_r != pll_ctrl_pkg::FRAME_BITS_CNT) begin
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Soft reset and frequency change strobes last one cycle only.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      soft_rst_r <= 1'b0;
      freq_chg_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_take && (wr_addr == pll_ctrl_pkg::ADDR_ID)
                    && wr_data[pll_ctrl_pkg::SWRST_BIT];
      freq_chg_r <= wr_take && !soft_rst_r && ((wr_addr == pll_ctrl_pkg::ADDR_INT)
                    || (wr_addr == pll_ctrl_pkg::ADDR_FRAC));
    end
  end

  // Writable registers; the identifier has no storage at all.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr_r <= pll_ctrl_pkg::PTR_RST;
      power_r <= pll_ctrl_pkg::POWER_RST;
      aux_r <= pll_ctrl_pkg::AUX_RST;
    end else if (soft_rst_r) begin
      ptr_r <= pll_ctrl_pkg::PTR_RST;
      power_r <= pll_ctrl_pkg::POWER_RST;
      aux_r <= pll_ctrl_pkg::AUX_RST;
    end else if (wr_take) begin
      case (wr_addr)
        pll_ctrl_pkg::ADDR_ID: begin
          ptr_r <= wr_data[pll_ctrl_pkg::PTR_MSB:0];
        end
        pll_ctrl_pkg::ADDR_POWER: begin
          power_r <= wr_data[pll_ctrl_pkg::POWER_W-1:0];
        end
        pll_ctrl_pkg::ADDR_AUX: begin
          aux_r <= wr_data[pll_ctrl_pkg::AUX_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data selected by the pointer; unmapped addresses read zero.
  always_comb begin
    case (ptr_r)
      pll_ctrl_pkg::ADDR_ID: rd_word = SUBSYS_ID;
      pll_ctrl_pkg::ADDR_POWER: rd_word = {15'h0000, power_r};
      pll_ctrl_pkg::ADDR_AUX: rd_word = {8'h00, aux_r};
      default: rd_word = 24'h000000;
    endcase
  end

  // Read-back starts on the first clock of a frame and needs no select, so
  // a host that never raises select keeps the read data on the shared pin.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      read_active_r <= 1'b0;
      rd_shift_r <= 24'h000000;
    end else if (soft_rst_r || rise[2]) begin
      read_active_r <= 1'b0;
    end else if (rise[0]) begin
      if (bit_cnt_r == 6'h00) begin
        read_active_r <= 1'b1;
        rd_shift_r <= rd_word;
      end else begin
        rd_shift_r <= {rd_shift_r[22:0], 1'b0};
      end
    end
  end

  // Shared pin: lock detect or read data; released after a foreign chip address.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_detect_serial_out <= 1'b0;
      lock_detect_serial_oe_out <= 1'b0;
    end else begin
      lock_detect_serial_out <= read_active_r ? rd_shift_r[23] : filt_r[4];
      lock_detect_serial_oe_out <= chip_ok_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Chip enable source and keep-alive overrides. Power-down only gates the
  // enables; register contents are never touched by it.
  assign ce = power_r[pll_ctrl_pkg::PWR_PIN_SEL] ? filt_r[3]
              : power_r[pll_ctrl_pkg::PWR_SPI_EN];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chip_enable_out <= 1'b0;
    end else begin
      chip_enable_out <= ce;
    end
  end

  generate
    for (gi = 0; gi < pll_ctrl_pkg::KEEP_N; gi++) begin : g_keep
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          blk_en_r[gi] <= 1'b0;
        end else begin
          blk_en_r[gi] <= ce || power_r[pll_ctrl_pkg::PWR_KEEP_LSB + gi];
        end
      end
    end
  endgenerate

  // Bit order follows the keep-alive fields, bias first.
  assign bias_en_out = blk_en_r[0];
  assign hold_phase_detector_active_out = blk_en_r[1];
  assign hold_charge_pump_active_out = blk_en_r[2];
  assign ref_buffer_en_out = blk_en_r[3];
  assign hold_divider_buffer_active_out = blk_en_r[4];
  assign hold_output_driver_active_out = blk_en_r[5];

  //////////////////////////////////////////////////////////////////////////////
  // Auxiliary port runs off comparison clock edges from the synchroniser.
  pll_aux_serial_port u_aux (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .soft_rst_in(soft_rst_r),
    .start_in(freq_chg_r),
    .word_in(aux_r),
    .pfd_level_in(filt_r[5]),
    .pfd_fall_in(fall[5]),
    .aux_clk_out(aux_clk_out),
    .aux_data_out(aux_data_pin_out),
    .aux_sel_out(aux_sel_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  sequence s_ptr_write;
    wr_take && wr_addr == 5'h00 && !wr_data[5];
  endsequence
  sequence s_reset_write;
    wr_take && wr_addr == 5'h00 && wr_data[5];
  endsequence

  swrst_pulse_a: assert property (s_reset_write |=> soft_rst_r ##1 !soft_rst_r)
    else $error("Soft reset was not a single pulse.");
  swrst_defaults_a: assert property (soft_rst_r |=> power_r == 9'h002 && aux_r == 16'h0000
                                     && ptr_r == 5'h00)
    else $error("Soft reset left a register off its default.");
  ptr_capture_a: assert property (s_ptr_write |=> ptr_r == $past(frame_r[12:8]))
    else $error("Read pointer did not capture the written address.");
  id_read_a: assert property (rise[0] && bit_cnt_r == 6'h00 && ptr_r == 5'h00 && !rise[2]
                              && !soft_rst_r |=> rd_shift_r == SUBSYS_ID)
    else $error("Identifier read returned a wrong value.");
  ld_restore_a: assert property (rise[2] |=> !read_active_r ##1
                                 lock_detect_serial_out == $past(filt_r[4]))
    else $error("Select rising edge did not restore lock detect.");
  read_load_a: assert property (rise[0] && bit_cnt_r == 6'h00 && !rise[2] && !soft_rst_r
                                |=> read_active_r && rd_shift_r == $past(rd_word))
    else $error("Read data was not loaded at frame start.");
  pin_enable_a: assert property (power_r[0] && !filt_r[3] |=> !chip_enable_out)
    else $error("Enable pin low did not power down.");
  spi_enable_a: assert property (!power_r[0] |=> chip_enable_out == $past(power_r[1]))
    else $error("Register chip enable was not followed.");
  keep_alive_a: assert property (##1 (blk_en_r & $past(power_r[7:2])) == $past(power_r[7:2]))
    else $error("A kept block was powered down.");
  power_down_a: assert property (!ce && power_r[7:2] == 6'h00 ##1 $stable(power_r)
                                 |-> blk_en_r == 6'h00)
    else $error("A block stayed on without chip enable.");
endmodule

/* sim/host_serial_master.sv */
/*
  Behavioural host master for the open-mode serial port: shifts 32-bit frames
  and collects read-back bits. Assumes clk_in is the 100 MHz system clock.
*/
`timescale 1ns/1ps
module host_serial_master (
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic sclk_out,
  output logic sdi_out,
  output logic sel_out
);
  // Lines idle low before the first frame.
  initial begin
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    sel_out = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One frame of 24 data, 5 address and 3 chip bits, MSB first.
  // A read needs a pointer frame first; the caller sequences that.
  task automatic frame(input logic [23:0] d, input logic [4:0] a,
                       input logic [2:0] chip, output logic [23:0] rd);
    logic [31:0] w;
    w = {d, a, chip};
    rd = 24'h000000;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_in);
      sclk_out <= 1'b0;
      sdi_out <= w[31-i];
      repeat (10) @(posedge clk_in);
      // Sampling just before the next rise leaves the filtered pin time to settle.
      if (i > 0 && i < 25) begin
        rd[24-i] = sdo_in;
      end
      sclk_out <= 1'b1;
      repeat (9) @(posedge clk_in);
    end
    @(posedge clk_in);
    sclk_out <= 1'b0;
    // Released data line shows the inverse so a stale bit is never trusted.
    sdi_out <= ~w[0];
    repeat (10) @(posedge clk_in);
    sel_out <= 1'b1;
    repeat (12) @(posedge clk_in);
    sel_out <= 1'b0;
    repeat (12) @(posedge clk_in);
  endtask
endmodule

/* sim/test_pll_serial_control_regs.sv */
/*
  Self-checking bench for the serial control block: power table, read-back,
  auxiliary port and soft reset. Assumes the host model drives the serial pins.
*/
`timescale 1ns/1ps
module test_pll_serial_control_regs;
  localparam logic [23:0] ID_VAL = 24'h3c0f12; // Arbitrary value.
  typedef struct {logic [8:0] pwr; logic pin; logic [6:0] exp;} row_t;
  logic clk_in, rst_n_in, sclk, sdi, sel, pin, lock, pfd;
  logic sdo, oe, aclk, adata, asel, ce, bias, pfd_on, cp, refb, divb, gpo;
  logic [3:0] pfd_cnt;
  logic [23:0] rd;
  logic [6:0] pw;
  int failures, samples_checked;
  row_t rows[11] = '{'{9'h002, 1'b0, 7'h7f}, '{9'h000, 1'b1, 7'h00},
    '{9'h001, 1'b1, 7'h7f}, '{9'h001, 1'b0, 7'h00}, '{9'h004, 1'b0, 7'h02},
    '{9'h008, 1'b0, 7'h04}, '{9'h010, 1'b0, 7'h08}, '{9'h020, 1'b0, 7'h10},
    '{9'h040, 1'b0, 7'h20}, '{9'h080, 1'b0, 7'h40}, '{9'h0fc, 1'b0, 7'h7e}};
  assign pw = {gpo, divb, refb, cp, pfd_on, bias, ce};

  pll_serial_control_regs #(.SUBSYS_ID(ID_VAL)) i_pll_serial_control_regs (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .sdi_in(sdi),
    .port_select_strobe_in(sel), .chip_enable_pin_in(pin), .lock_detect_in(lock),
    .pfd_clk_in(pfd), .lock_detect_serial_out(sdo), .lock_detect_serial_oe_out(oe),
    .aux_clk_out(aclk), .aux_data_pin_out(adata), .aux_sel_out(asel),
    .chip_enable_out(ce), .bias_en_out(bias), .hold_phase_detector_active_out(pfd_on),
    .hold_charge_pump_active_out(cp), .ref_buffer_en_out(refb),
    .hold_divider_buffer_active_out(divb), .hold_output_driver_active_out(gpo));
  host_serial_master i_host_serial_master (.clk_in(clk_in), .sdo_in(sdo),
    .sclk_out(sclk), .sdi_out(sdi), .sel_out(sel));

  //////////////////////////////////////////////////////////////////////////////
  // System clock, and a comparison clock of ten system periods.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    pfd_cnt <= (pfd_cnt == 4'h4) ? 4'h0 : pfd_cnt + 4'h1;
    if (pfd_cnt == 4'h4) begin
      pfd <= ~pfd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    i_host_serial_master.frame(d, a, 3'h0, rd);
  endtask
  task automatic rdreg(input logic [4:0] a);
    wr(5'h00, {19'h0, a});
    i_host_serial_master.frame({19'h0, a}, 5'h00, 3'h0, rd);
  endtask
  // Collects one auxiliary transfer; times are system cycles from the start.
  task automatic aux_cap();
    int n, first, last, s0, s1;
    logic pa, ps;
    logic [15:0] bits;
    n = 0;
    s1 = 0;
    pa = 1'b0;
    ps = 1'b0;
    for (int t = 0; t < 2000 && s1 == 0; t++) begin
      @(posedge clk_in);
      if (aclk && !pa) begin
        bits = {bits[14:0], adata};
        if (n == 0) first = t;
        last = t;
        n++;
      end
      if (asel && !ps) s0 = t;
      if (!asel && ps) s1 = t;
      pa = aclk;
      ps = asel;
    end
    if (s1 == 0) begin
      failures++;
      summarize();
    end
    check(bits, 32'h0000c3a5);
    check(n, 32'd16);
    check(last - first, 32'd150);
    check(s1 - s0, 32'd10);
    check((s0 - last >= 24) && (s0 - last <= 26), 32'd1);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, power table, then hand-written cases.
  initial begin
    failures = 0;
    samples_checked = 0;
    rst_n_in = 1'b0;
    pin = 1'b0;
    lock = 1'b0;
    pfd = 1'b0;
    pfd_cnt = 4'h0;
    repeat (10) @(posedge clk_in);
    check({pw, oe}, 32'h0);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    check({pw, oe}, 32'hff);
    $display("reset test done");
    foreach (rows[i]) begin
      @(posedge clk_in);
      pin <= rows[i].pin;
      wr(5'h01, {15'h0, rows[i].pwr});
      repeat (8) @(posedge clk_in);
      check(pw, rows[i].exp);
    end
    $display("power table done");
    rdreg(5'h00);
    check(rd, ID_VAL);
    wr(5'h01, 24'h0000a5);
    rdreg(5'h01);
    check(rd, 32'h0000a5);
    @(posedge clk_in);
    lock <= 1'b1;
    repeat (8) @(posedge clk_in);
    check({sdo, oe}, 32'h3);
    lock <= 1'b0;
    repeat (8) @(posedge clk_in);
    check({sdo, oe}, 32'h1);
    $display("read-back test done");
    wr(5'h05, 24'h00c3a5);
    rdreg(5'h05);
    check(rd, 32'h00c3a5);
    for (int j = 3; j < 5; j++) begin
      fork
        wr(j[4:0], 24'h000000);
        aux_cap();
      join
    end
    $display("aux test done");
    // A frame for another chip address must store nothing and release the shared pin.
    i_host_serial_master.frame(24'h000000, 5'h01, 3'h5, rd);
    check({pw, oe}, 32'ha4);
    $display("foreign chip test done");
    wr(5'h01, 24'h000000);
    wr(5'h00, 24'h000021);
    repeat (4) @(posedge clk_in);
    check({pw, oe}, 32'hff);
    rdreg(5'h01);
    check(rd, 32'h000002);
    rdreg(5'h05);
    check(rd, 32'h000000);
    wr(5'h01, 24'h000000);
    wr(5'h00, 24'h000001);
    repeat (4) @(posedge clk_in);
    check(pw, 32'h00);
    $display("soft reset test done");
    // A hardware reset in mid-run must bring the power register back to its default.
    rst_n_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    check({pw, oe}, 32'h0);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    check({pw, oe}, 32'hff);
    $display("mid-run reset test done");
    summarize();
  end
endmodule
